// *** hdl/nfc_cycle.sv ***
// One strobed byte cycle on the flash pins: command, address, write or read
`timescale 1ns/100ps
`include "nfc_defs.svh"
module nfc_cycle import nfc_pkg::*; (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire nfc_kind_e kind_in,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] io_in,
  output nfc_pins_s pins_out,
  output logic [7:0] rbyte_out,
  output logic done_out,
  output logic idle_out
);
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_LOW = 2'b01,
    CY_HIGH = 2'b10
  } nfc_cy_e;
  localparam nfc_pins_s PINS_REST = '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                                      io: 8'h00, io_oe: 1'b0};
  nfc_cy_e state, next_state;
  nfc_pins_s next_pins;
  logic [7:0] next_rbyte;

  assign done_out = state == CY_HIGH;
  assign idle_out = state == CY_IDLE;

  always_comb
  begin
    next_state = state;
    next_pins = pins_out;
    next_rbyte = rbyte_out;
    unique case (state)
      CY_IDLE:
      begin
        next_pins = PINS_REST;
        if (start_in)
        begin
          // Latch levels and strobe fall together; device takes the byte on the rise
          next_pins.cle = kind_in == K_CMD; // see RL21
          next_pins.ale = kind_in == K_ADDR; // see RL21
          next_pins.we_n = kind_in == K_RDATA;
          next_pins.re_n = kind_in != K_RDATA;
          next_pins.io = byte_in;
          next_pins.io_oe = kind_in != K_RDATA;
          next_state = CY_LOW;
        end
      end
      CY_LOW:
      begin
        // Latch levels stay one more cycle for hold after the rising strobe
        if (!pins_out.re_n)
          next_rbyte = io_in;
        next_pins.we_n = 1'b1;
        next_pins.re_n = 1'b1;
        next_state = CY_HIGH;
      end
      CY_HIGH:
      begin
        next_pins = PINS_REST;
        next_state = CY_IDLE;
      end
      default:
      begin
        next_pins = PINS_REST;
        next_state = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= CY_IDLE;
      pins_out <= PINS_REST;
      rbyte_out <= 8'h00;
    end
    else
    begin
      state <= next_state;
      pins_out <= next_pins;
      rbyte_out <= next_rbyte;
    end
  end

  a_latch_on_rise: assert property (@(posedge clk_in) disable iff (srst_in) // see RL21
    (!pins_out.we_n && pins_out.cle) |-> !pins_out.ale ##1 (pins_out.we_n && pins_out.cle))
    else $error("Command latch dropped before the write strobe rose");
  a_strobes_apart: assert property (@(posedge clk_in) disable iff (srst_in) // see RL23
    !pins_out.we_n |-> pins_out.re_n ##1 pins_out.we_n)
    else $error("Write strobe overlapped read strobe or stayed low");
endmodule // nfc_cycle

// *** hdl/nfc_defs.svh ***
// Command codes, field positions and timing counts for the flash host
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH
`define NFC_CMD_READ_OPEN 8'h00
`define NFC_CMD_READ_GO 8'h30
`define NFC_CMD_CACHE_NEXT 8'h31
`define NFC_CMD_CACHE_LAST 8'h3f
`define NFC_CMD_DISTRICT 8'h60
`define NFC_CMD_PROG_OPEN 8'h80
`define NFC_CMD_PROG_SECOND 8'h81
`define NFC_CMD_PROG_MID 8'h11
`define NFC_CMD_PROG_GO 8'h10
`define NFC_CMD_COL_CHANGE 8'h85
`define NFC_CMD_STATUS 8'h70
`define NFC_PAGE_MSB 5
`define NFC_DIST_BIT 6
`define NFC_HALF_BIT 17
`define NFC_LAST_PAGE 6'h3f
`define NFC_STAT_FAIL 0
`define NFC_ADDR_LAST 3'h4
`define NFC_COL_LAST 3'h1
`define NFC_ROW_FIRST 3'h2
`define NFC_CLK_NS 50
`define NFC_WB_NS 100
`define NFC_WB_CYC ((`NFC_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// *** hdl/nfc_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module nfc_fifo import nfc_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr, rptr, next_wptr, next_rptr;
  logic push, pop;

  // Extra pointer bit tells full from empty
  assign in_ready_out = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wptr != rptr;
  assign out_data_out = mem[rptr[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wptr[AW-1:0]] <= in_data_in;
  end
endmodule // nfc_fifo

// *** hdl/nfc_host.sv ***
// Flash host controller: read, cached read, multi read and program sequencer
//------------------------------------------------------------------------------
// Overview of operation
// RL1 - Read opens with 00h, five address cycles, then 30h starts the fetch.
// RL2 - Device holds 00h after power-on; host still sends 00h each time.
// RL3 - 31h makes device prefetch next page while cache page is read out.
// RL4 - First normal read passes page through buffer to cache, busy meanwhile.
// RL5 - 31h only after ready; device signals cache transfer end on ready/busy.
// RL6 - Cached page may be read out while the next fetch runs.
// RL7 - Later 31h waits for fetch end, so busy length varies.
// RL8 - 3Fh moves last fetched page to cache without new fetch.
// RL9 - Cached read restarts from the beginning whenever the block changes.
// RL10 - Multi read: 60h plus row per district, then 30h; busy throughout.
// RL11 - After multi read ready, data comes out from the given column.
// RL12 - Both districts use identical page-in-block bits.
// RL13 - Even blocks district 0, odd district 1, pair within one half.
// RL14 - At most one block per district in one multi operation.
// RL15 - District addresses may come in either order, blocks unrelated.
// RL16 - Write protect held high through a multi page read.
// RL17 - 10h after address and data starts the page program.
// RL18 - 85h plus two column cycles redirects further program data.
// RL19 - Column change may repeat any number of times before programming.
// RL20 - After multi program, status bit one set if either page fails; the host takes the fail flag from bit 0.
// RL21 - Command byte taken on write strobe rise with command latch high.
// RL22 - Column in cycles one and two, row in three to five, upper bits low.
// RL23 - During read busy both strobes stay high; only reset or status allowed.
// RL24 - Multi program: 80h, addr, data, 11h, 81h, addr, data, 10h.
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`include "nfc_defs.svh"
module nfc_host import nfc_pkg::*; (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire nfc_req_s req_in,
  input wire logic wdata_valid_in,
  output logic wdata_ready_out,
  input wire logic [7:0] wdata_in,
  output logic rdata_valid_out,
  input wire logic rdata_ready_in,
  output logic [7:0] rdata_out,
  input wire logic protect_in,
  output logic done_out,
  output logic err_out,
  output logic [7:0] status_out,
  output logic fail_out,
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic wp_n_out,
  output logic [7:0] io_out,
  output logic io_oe_out,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n_in
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD1 = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_CMD2 = 3'b100,
    ST_WAIT_WB = 3'b101,
    ST_WAIT_RDY = 3'b110,
    ST_RDATA = 3'b111
  } nfc_st_e;
  nfc_st_e state, next_state;
  nfc_req_s req, next_req;
  logic [12:0] idx, next_idx;
  logic pass, next_pass, stat, next_stat, inflight, next_inflight;
  logic cache_ok, next_cache_ok;
  logic [17:0] cache_row, next_cache_row;
  logic next_done, next_err, next_fail, next_wp_n, next_ce_n;
  logic [7:0] next_status;
  logic cyc_start, cyc_done, cyc_idle;
  nfc_kind_e cyc_kind;
  logic [7:0] cyc_byte, cyc_rbyte;
  nfc_pins_s pins;
  logic wf_valid, wf_pop, rf_ready, rf_push;
  logic [7:0] wf_data;
  logic [17:0] row_sel;
  logic pair_ok, is_status, last_byte;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  //------------------------------------------------------------------------------
  // Byte engine and data buffers
  //------------------------------------------------------------------------------
  nfc_cycle u_cycle (.clk_in(clk_in), .srst_in(srst_in), .start_in(cyc_start),
    .kind_in(cyc_kind), .byte_in(cyc_byte), .io_in(io_in), .pins_out(pins),
    .rbyte_out(cyc_rbyte), .done_out(cyc_done), .idle_out(cyc_idle));

  // Program data stalls the sequencer when the writer falls behind
  nfc_fifo #(.WIDTH(8), .DEPTH(16)) u_wfifo (.clk_in(clk_in), .srst_in(srst_in),
    .in_valid_in(wdata_valid_in), .in_ready_out(wdata_ready_out), .in_data_in(wdata_in),
    .out_valid_out(wf_valid), .out_ready_in(wf_pop), .out_data_out(wf_data));

  // Read strobes are held back while the reader is not draining
  nfc_fifo #(.WIDTH(8), .DEPTH(16)) u_rfifo (.clk_in(clk_in), .srst_in(srst_in),
    .in_valid_in(rf_push), .in_ready_out(rf_ready), .in_data_in(cyc_rbyte),
    .out_valid_out(rdata_valid_out), .out_ready_in(rdata_ready_in),
    .out_data_out(rdata_out));

  assign cle_out = pins.cle;
  assign ale_out = pins.ale;
  assign we_n_out = pins.we_n;
  assign re_n_out = pins.re_n;
  assign io_out = pins.io;
  assign io_oe_out = pins.io_oe;
  assign req_ready_out = state == ST_IDLE;

  //------------------------------------------------------------------------------
  // Request checks and byte selection
  //------------------------------------------------------------------------------
  assign pair_ok = req_in.row[`NFC_PAGE_MSB:0] == req_in.row2[`NFC_PAGE_MSB:0] // see RL12
    && req_in.row[`NFC_DIST_BIT] != req_in.row2[`NFC_DIST_BIT] // see RL14
    && req_in.row[`NFC_HALF_BIT] == req_in.row2[`NFC_HALF_BIT]; // see RL13
  assign row_sel = pass ? req.row2 : req.row; // see RL15
  assign is_status = stat || req.op == OP_STATUS;
  assign last_byte = idx == req.len - 13'd1;

  always_comb
  begin
    cyc_byte = 8'h00;
    cyc_kind = K_CMD;
    unique case (state)
      ST_CMD1:
        if (stat)
          cyc_byte = `NFC_CMD_STATUS;
        else
          unique case (req.op)
            OP_READ: cyc_byte = `NFC_CMD_READ_OPEN; // see RL1
            OP_CACHE_NEXT: cyc_byte = `NFC_CMD_CACHE_NEXT; // see RL3
            OP_CACHE_LAST: cyc_byte = `NFC_CMD_CACHE_LAST; // see RL8
            OP_MULTI_READ: cyc_byte = `NFC_CMD_DISTRICT; // see RL10
            OP_PROGRAM: cyc_byte = `NFC_CMD_PROG_OPEN;
            OP_COL_CHANGE: cyc_byte = `NFC_CMD_COL_CHANGE; // see RL18
            OP_MULTI_PROG: cyc_byte = pass ? `NFC_CMD_PROG_SECOND : `NFC_CMD_PROG_OPEN;
            OP_STATUS: cyc_byte = `NFC_CMD_STATUS;
          endcase
      ST_ADDR:
      begin
        cyc_kind = K_ADDR;
        unique case (idx[2:0]) // see RL22
          3'h0: cyc_byte = req.col[7:0];
          3'h1: cyc_byte = {3'h0, req.col[12:8]};
          3'h2: cyc_byte = row_sel[7:0];
          3'h3: cyc_byte = row_sel[15:8];
          default: cyc_byte = {6'h00, row_sel[17:16]};
        endcase
      end
      ST_WDATA:
      begin
        cyc_kind = K_WDATA;
        cyc_byte = wf_data;
      end
      ST_RDATA: cyc_kind = K_RDATA;
      default:
        if (req.op == OP_READ || req.op == OP_MULTI_READ)
          cyc_byte = `NFC_CMD_READ_GO; // see RL1
        else if (req.op == OP_MULTI_PROG && !pass)
          cyc_byte = `NFC_CMD_PROG_MID; // see RL24
        else
          cyc_byte = `NFC_CMD_PROG_GO; // see RL17
    endcase
  end

  //------------------------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_req = req;
    next_idx = idx;
    next_pass = pass;
    next_stat = stat;
    next_inflight = inflight;
    next_cache_ok = cache_ok;
    next_cache_row = cache_row;
    next_done = 1'b0;
    next_err = 1'b0;
    next_status = status_out;
    next_fail = fail_out;
    cyc_start = 1'b0;
    wf_pop = 1'b0;
    rf_push = 1'b0;
    // Strobes only move in byte states, so busy waits keep them high
    if (cyc_idle && !inflight && state inside {ST_CMD1, ST_ADDR, ST_CMD2}) // see RL23
    begin
      cyc_start = 1'b1;
      next_inflight = 1'b1;
    end
    if (cyc_done)
      next_inflight = 1'b0;
    unique case (state)
      ST_IDLE:
        if (req_valid_in)
        begin
          if (((req_in.op == OP_MULTI_READ || req_in.op == OP_MULTI_PROG) && !pair_ok)
              || (req_in.op == OP_CACHE_NEXT
                  && (!cache_ok || cache_row[`NFC_PAGE_MSB:0] == `NFC_LAST_PAGE)) // see RL9
              || (req_in.op == OP_CACHE_LAST && !cache_ok))
            next_err = 1'b1;
          else
          begin
            next_req = req_in;
            next_idx = '0;
            next_pass = 1'b0;
            next_stat = 1'b0;
            next_state = ST_CMD1;
            next_cache_ok = req_in.op == OP_READ || req_in.op == OP_CACHE_NEXT;
            next_cache_row = req_in.op == OP_READ ? req_in.row : cache_row + 18'd1;
          end
        end
      ST_CMD1:
        if (cyc_done)
        begin
          next_idx = '0;
          if (is_status)
            next_state = ST_RDATA;
          else if (req.op == OP_CACHE_NEXT || req.op == OP_CACHE_LAST)
            next_state = ST_WAIT_WB;
          else
          begin
            next_idx = req.op == OP_MULTI_READ ? 13'(`NFC_ROW_FIRST) : 13'd0;
            next_state = ST_ADDR;
          end
        end
      ST_ADDR:
        if (cyc_done)
        begin
          next_idx = idx + 13'd1;
          if (idx[2:0] == (req.op == OP_COL_CHANGE ? `NFC_COL_LAST : `NFC_ADDR_LAST))
          begin
            next_idx = '0;
            if (req.op == OP_MULTI_READ && !pass)
            begin
              next_pass = 1'b1;
              next_state = ST_CMD1;
            end
            else if (req.op == OP_READ || req.op == OP_MULTI_READ)
              next_state = ST_CMD2;
            else
              next_state = ST_WDATA;
          end
        end
      ST_WDATA:
      begin
        if (cyc_idle && !inflight && wf_valid)
        begin
          cyc_start = 1'b1;
          wf_pop = 1'b1;
          next_inflight = 1'b1;
        end
        if (cyc_done)
        begin
          next_idx = idx + 13'd1;
          if (last_byte)
          begin
            next_idx = '0;
            // Without commit the page stays open for another column change
            if (req.commit || req.op == OP_MULTI_PROG) // see RL19
              next_state = ST_CMD2;
            else
            begin
              next_done = 1'b1;
              next_state = ST_IDLE;
            end
          end
        end
      end
      ST_CMD2:
        if (cyc_done)
        begin
          next_idx = '0;
          next_state = ST_WAIT_WB;
        end
      ST_WAIT_WB:
      begin
        // Ready/busy is not valid until the device has had time to pull it low
        next_idx = idx + 13'd1;
        if (idx == 13'(`NFC_WB_CYC))
          next_state = ST_WAIT_RDY;
      end
      ST_WAIT_RDY:
        if (ready_busy_n_in) // see RL5
        begin
          next_idx = '0;
          if (req.op == OP_MULTI_PROG && !pass)
          begin
            next_pass = 1'b1;
            next_state = ST_CMD1;
          end
          else if (req.op inside {OP_PROGRAM, OP_COL_CHANGE, OP_MULTI_PROG})
          begin
            next_stat = 1'b1;
            next_state = ST_CMD1;
          end
          else
            next_state = ST_RDATA; // see RL11
        end
      ST_RDATA:
      begin
        if (cyc_idle && !inflight && (is_status || rf_ready))
        begin
          cyc_start = 1'b1;
          next_inflight = 1'b1;
        end
        if (cyc_done)
        begin
          next_idx = idx + 13'd1;
          rf_push = !is_status;
          if (is_status)
          begin
            next_status = cyc_rbyte;
            next_fail = cyc_rbyte[`NFC_STAT_FAIL]; // see RL20
          end
          if (is_status || last_byte)
          begin
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
    endcase
    // Protect is released for the whole of any operation, multi read included
    next_wp_n = next_state != ST_IDLE || !protect_in; // see RL16
    next_ce_n = next_state == ST_IDLE;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= ST_IDLE;
      req <= '0;
      idx <= '0;
      pass <= 1'b0;
      stat <= 1'b0;
      inflight <= 1'b0;
      cache_ok <= 1'b0;
      cache_row <= '0;
      done_out <= 1'b0;
      err_out <= 1'b0;
      status_out <= 8'h00;
      fail_out <= 1'b0;
      wp_n_out <= 1'b0;
      ce_n_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      req <= next_req;
      idx <= next_idx;
      pass <= next_pass;
      stat <= next_stat;
      inflight <= next_inflight;
      cache_ok <= next_cache_ok;
      cache_row <= next_cache_row;
      done_out <= next_done;
      err_out <= next_err;
      status_out <= next_status;
      fail_out <= next_fail;
      wp_n_out <= next_wp_n;
      ce_n_out <= next_ce_n;
    end
  end

  //------------------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------------------
  a_read_close: assert property (!we_n_out && cle_out && io_out == `NFC_CMD_READ_GO // see RL1
    |-> req.op inside {OP_READ, OP_MULTI_READ} ##[1:4] state == ST_WAIT_WB)
    else $error("30h sent outside a read or not followed by busy wait");
  a_cache_after_ready: assert property (!we_n_out && cle_out // see RL5
    && io_out == `NFC_CMD_CACHE_NEXT |-> $past(state, 2) == ST_IDLE || $past(ready_busy_n_in, 2))
    else $error("31h issued while busy");
  a_busy_quiet: assert property (state == ST_WAIT_RDY |-> we_n_out && re_n_out) // see RL23
    else $error("Strobe moved during a busy wait");
  a_wp_multi: assert property (state != ST_IDLE && req.op == OP_MULTI_READ |-> wp_n_out) // see RL16
    else $error("Write protect low during multi read");
  a_same_page: assert property (state == ST_CMD1 && req.op inside {OP_MULTI_READ, OP_MULTI_PROG} // see RL12
    |-> req.row[`NFC_PAGE_MSB:0] == req.row2[`NFC_PAGE_MSB:0])
    else $error("District pages differ");
  a_district_pair: assert property (state == ST_ADDR && req.op == OP_MULTI_READ // see RL13
    |-> req.row[`NFC_DIST_BIT] != req.row2[`NFC_DIST_BIT]
        && req.row[`NFC_HALF_BIT] == req.row2[`NFC_HALF_BIT])
    else $error("District blocks not a legal pair");
  a_addr_upper: assert property (!we_n_out && ale_out && state == ST_ADDR && idx == 13'd1 // see RL22
    |-> io_out[7:5] == 3'h0)
    else $error("Column upper bits not low");
  a_prog_go: assert property (!we_n_out && cle_out && io_out == `NFC_CMD_PROG_GO // see RL17
    |-> req.op inside {OP_PROGRAM, OP_COL_CHANGE, OP_MULTI_PROG} && $past(state, 2) != ST_IDLE)
    else $error("10h sent without program data phase");
  a_cache_block: assert property (state == ST_CMD1 && req.op == OP_CACHE_NEXT // see RL9
    |-> cache_ok && cache_row[`NFC_PAGE_MSB:0] != 6'h00)
    else $error("Cached read crossed a block");
  a_fail_latch: assert property (state == ST_RDATA && stat && cyc_done // see RL20
    |=> fail_out == $past(cyc_rbyte[0]) && done_out)
    else $error("Program fail bit not reported");
  c_read: cover property (state == ST_RDATA && req.op == OP_READ && cyc_done && last_byte);
  c_cache: cover property (state == ST_WAIT_RDY && req.op == OP_CACHE_NEXT);
  c_multi_prog: cover property (state == ST_CMD1 && req.op == OP_MULTI_PROG && pass);
  c_col_change: cover property (state == ST_WDATA && req.op == OP_COL_CHANGE && cyc_done);
endmodule // nfc_host

// *** hdl/nfc_pkg.sv ***
// Types shared by the flash host modules
package nfc_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_CACHE_NEXT = 3'b001,
    OP_CACHE_LAST = 3'b010,
    OP_MULTI_READ = 3'b011,
    OP_PROGRAM = 3'b100,
    OP_COL_CHANGE = 3'b101,
    OP_MULTI_PROG = 3'b110,
    OP_STATUS = 3'b111
  } nfc_op_e;
  typedef enum logic [1:0] {
    K_CMD = 2'b00,
    K_ADDR = 2'b01,
    K_WDATA = 2'b10,
    K_RDATA = 2'b11
  } nfc_kind_e;
  typedef struct packed {
    nfc_op_e op;
    logic commit;
    logic [12:0] col;
    logic [17:0] row;
    logic [17:0] row2;
    logic [12:0] len;
  } nfc_req_s;
  typedef struct packed {
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io;
    logic io_oe;
  } nfc_pins_s;
endpackage

// *** test/nfc_flash_model.sv ***
// Behavioural flash device facing the host pins
`timescale 1ns/100ps
module nfc_flash_model #(
  parameter int BUSY_CYC = 6
) (
  input wire logic clk_in,
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic fail_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic busy_out
);
  logic [31:0] hist = '0;
  logic [12:0] col = '0;
  logic [12:0] wcol = '0;
  logic [17:0] row = '0;
  logic [7:0] last = '0;
  logic [7:0] wlast = '0;
  logic [2:0] a;
  logic go = 1'b0;
  logic ack = 1'b0;
  logic stat = 1'b0;
  int acnt = 0;
  int bcnt = 0;
  // Released bus shows the inverse, never a stale byte
  assign io_out = re_n_in ? ~last : last;
  assign busy_out = (go != ack) || (bcnt != 0);
  always @(posedge clk_in)
    if (go != ack)
    begin
      ack <= go;
      bcnt <= BUSY_CYC;
    end
    else if (bcnt != 0)
      bcnt <= bcnt - 1;
  // Strobe edges only; a deselected device ignores both
  always @(posedge we_n_in or negedge re_n_in)
    if (!ce_n_in && !re_n_in)
    begin
      last = stat ? {7'h70, fail_in} : col[7:0] ^ row[7:0];
      col = col + 13'h1;
    end
    else if (!ce_n_in && cle_in)
    begin
      hist = {hist[23:0], io_in};
      stat = (io_in == 8'h70);
      acnt = 0;
      if (io_in inside {8'h31, 8'h3f, 8'h60})
        col = '0;
      if (io_in inside {8'h31, 8'h3f})
        row = row + 18'h1;
      if (io_in inside {8'h30, 8'h31, 8'h3f, 8'h10, 8'h11})
        go = ~go;
    end
    else if (!ce_n_in && ale_in)
    begin
      a = (hist[7:0] == 8'h60) ? 3'(acnt + 2) : 3'(acnt);
      case (a)
        3'h0: col[7:0] = io_in;
        3'h1: col[12:8] = io_in[4:0];
        3'h2: row[7:0] = io_in;
        3'h3: row[15:8] = io_in;
        default: row[17:16] = io_in[1:0];
      endcase
      acnt++;
    end
    else if (!ce_n_in)
    begin
      wlast = io_in;
      wcol = col;
      col = col + 13'h1;
    end
endmodule // nfc_flash_model

// *** test/nfc_host_tb_top.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module nfc_host_tb_top import nfc_pkg::*;;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid = 1'b0;
  nfc_req_s req = '0;
  logic wdata_valid = 1'b0;
  logic [7:0] wdata = '0;
  logic rdata_ready = 1'b0;
  logic protect = 1'b1;
  logic fail = 1'b0;
  logic req_ready, wdata_ready, rdata_valid, done, err, fail_o, io_oe, busy;
  logic ce_n, cle, ale, we_n, re_n, wp_n;
  logic [7:0] rdata, status, io_o, io_i;
  logic [7:0] rq[$];
  int failures = 0;
  int check_count = 0;
  int got;
  initial forever #25 clk_in = ~clk_in;
  // Far side stalls every other cycle
  always @(negedge clk_in) rdata_ready <= ~rdata_ready;
  always @(posedge clk_in) if (rdata_valid && rdata_ready) rq.push_back(rdata);
  nfc_host dut (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_in(req), .wdata_valid_in(wdata_valid),
    .wdata_ready_out(wdata_ready), .wdata_in(wdata), .rdata_valid_out(rdata_valid),
    .rdata_ready_in(rdata_ready), .rdata_out(rdata), .protect_in(protect), .done_out(done),
    .err_out(err), .status_out(status), .fail_out(fail_o), .ce_n_out(ce_n), .cle_out(cle),
    .ale_out(ale), .we_n_out(we_n), .re_n_out(re_n), .wp_n_out(wp_n), .io_out(io_o),
    .io_oe_out(io_oe), .io_in(io_i), .ready_busy_n_in(~busy));
  nfc_flash_model dev (.clk_in(clk_in), .ce_n_in(ce_n), .cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .re_n_in(re_n), .fail_in(fail), .io_in(io_o), .io_out(io_i),
    .busy_out(busy));
  task automatic finish_test();
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic op(input nfc_op_e o, input logic [12:0] c, input logic [17:0] r,
    input logic [17:0] r2, input logic [12:0] n, input logic cm, input logic expe);
    int k;
    rq = {};
    req <= '{o, cm, c, r, r2, n};
    req_valid <= 1'b1;
    @(negedge clk_in);
    req_valid <= 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1 && err !== 1'b1; k++)
    begin
      @(negedge clk_in);
      if (busy === 1'b1)
        `CHK({wp_n, we_n, re_n}, 3'h7)
      if (!(we_n && re_n))
        `CHK(io_oe, re_n)
    end
    if (k == 4000)
    begin
      failures++;
      finish_test();
    end
    `CHK(err, expe)
    @(negedge clk_in);
  endtask
  task automatic rd(input int n, input logic [7:0] c0, input logic [7:0] r);
    int k;
    for (k = 0; k < 400 && rq.size() < n; k++)
      @(negedge clk_in);
    `CHK(rq.size(), n)
    for (k = 0; k < n && k < rq.size(); k++)
      `CHK(rq[k], (c0 + 8'(k)) ^ r)
  endtask
  // Bounded fill; counts only words taken
  task automatic fill(input int n);
    got = 0;
    for (int k = 0; k < n; k++)
    begin
      wdata <= 8'(k);
      wdata_valid <= 1'b1;
      #1;
      if (wdata_ready === 1'b1)
        got++;
      @(negedge clk_in);
    end
    wdata_valid <= 1'b0;
  endtask
  // ---------------
  // Scenarios
  // ---------------
  task automatic t_read();
    op(OP_READ, 13'h1005, 18'h2a4c7, '0, 13'h14, 1'b1, 1'b0);
    rd(20, 8'h05, 8'hc7);
    `CHK(dev.hist[15:0], 16'h0030)
    `CHK(dev.row, 18'h2a4c7)
    `CHK(dev.col, 13'h1019)
  endtask
  task automatic t_cache();
    op(OP_CACHE_NEXT, '0, '0, '0, 13'h3, 1'b1, 1'b0);
    rd(3, 8'h00, 8'hc8);
    op(OP_CACHE_LAST, '0, '0, '0, 13'h2, 1'b1, 1'b0);
    rd(2, 8'h00, 8'hc9);
    `CHK(dev.hist[15:0], 16'h313f)
    op(OP_CACHE_LAST, '0, '0, '0, 13'h2, 1'b1, 1'b1);
  endtask
  task automatic t_multi_read();
    op(OP_MULTI_READ, '0, 18'h083, 18'h0c4, 13'h2, 1'b1, 1'b1);
    op(OP_MULTI_READ, '0, 18'h083, 18'h103, 13'h2, 1'b1, 1'b1);
    op(OP_MULTI_READ, '0, 18'h083, 18'h200c3, 13'h2, 1'b1, 1'b1);
    op(OP_MULTI_READ, '0, 18'h0c3, 18'h083, 13'h2, 1'b1, 1'b0);
    rd(2, 8'h00, 8'h83);
    `CHK(dev.hist[23:0], 24'h606030)
  endtask
  task automatic t_program();
    fill(4);
    op(OP_PROGRAM, 13'h010, 18'h040, '0, 13'h2, 1'b0, 1'b0);
    op(OP_COL_CHANGE, 13'h020, '0, '0, 13'h1, 1'b0, 1'b0);
    op(OP_COL_CHANGE, 13'h100, '0, '0, 13'h1, 1'b1, 1'b0);
    `CHK(dev.hist, 32'h85851070)
    `CHK({dev.wcol, dev.wlast}, 21'h10003)
    `CHK(fail_o, 1'b0)
  endtask
  task automatic t_multi_prog();
    fail = 1'b1;
    fill(17);
    `CHK(got, 16)
    op(OP_MULTI_PROG, '0, 18'h101, 18'h141, 13'h8, 1'b1, 1'b0);
    `CHK(dev.hist, 32'h11811070)
    `CHK({fail_o, status, dev.wlast}, 17'h1e10f)
    fail = 1'b0;
    op(OP_STATUS, '0, '0, '0, 13'h1, 1'b1, 1'b0);
    `CHK({fail_o, status}, 9'h0e0)
  endtask
  initial
  begin
    repeat (12) @(negedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    `CHK({ce_n, cle, ale, we_n, re_n, wp_n, io_oe, req_ready}, 8'h99)
    t_read();
    t_cache();
    t_multi_read();
    t_program();
    t_multi_prog();
    finish_test();
  end
endmodule // nfc_host_tb_top
